// >>> pkg/tec_pkg.sv
// Constants, register map and carrier types of the timestamp and event block.
// Assumes a single 250 MHz clock domain and an APB master with 32-bit data.
package tec_pkg;

  localparam int unsigned TEC_AW          = 8;
  localparam int unsigned TEC_NUM_EVENTS  = 11;
  localparam int unsigned TEC_NUM_STATS   = 5;
  localparam int unsigned TEC_EVT_ID_W    = 4;

  // Clock rate and the nanosecond step per clock
  localparam int unsigned TEC_CLK_MHZ     = 250;
  localparam logic [63:0] TEC_TICK_NS     = 64'(1000 / TEC_CLK_MHZ);

  // Register byte offsets
  localparam logic [7:0] TEC_OFS_CTRL     = 8'h00;
  localparam logic [7:0] TEC_OFS_CMD      = 8'h04;
  localparam logic [7:0] TEC_OFS_TIME_LO  = 8'h08;
  localparam logic [7:0] TEC_OFS_TIME_HI  = 8'h0c;
  localparam logic [7:0] TEC_OFS_CAPT_LO  = 8'h10;
  localparam logic [7:0] TEC_OFS_CAPT_HI  = 8'h14;
  localparam logic [7:0] TEC_OFS_STAT_SEL = 8'h18;
  localparam logic [7:0] TEC_OFS_STAT_CNT = 8'h1c;
  localparam logic [7:0] TEC_OFS_NTF_SEL  = 8'h20;
  localparam logic [7:0] TEC_OFS_NTF_SET  = 8'h24;
  localparam logic [7:0] TEC_OFS_STATUS   = 8'h28;

  // Field positions
  localparam int unsigned TEC_CTRL_SRC_BIT  = 0;
  localparam int unsigned TEC_CTRL_MODE_LSB = 1;
  localparam int unsigned TEC_CMD_CAPT_BIT  = 0;
  localparam int unsigned TEC_CMD_CLR_BIT   = 1;
  localparam int unsigned TEC_STS_NET_BIT   = 0;
  localparam int unsigned TEC_STS_PTP_BIT   = 1;
  localparam int unsigned TEC_STS_SLV_BIT   = 2;

  // Event indices
  localparam int unsigned TEC_EV_CAP_BEGIN  = 0;
  localparam int unsigned TEC_EV_CAP_FINISH = 1;
  localparam int unsigned TEC_EV_LINK_RATE  = 2;
  localparam int unsigned TEC_EV_ERROR      = 3;
  localparam int unsigned TEC_EV_WARNING    = 4;
  localparam int unsigned TEC_EV_INFO       = 5;
  localparam int unsigned TEC_EV_FIRST_ALARM_EVENT     = 6;
  localparam int unsigned TEC_EV_SECOND_ALARM_EVENT     = 7;
  localparam int unsigned TEC_EV_THIRD_ALARM_EVENT     = 8;
  localparam int unsigned TEC_EV_CAL_BEGIN  = 9;
  localparam int unsigned TEC_EV_CAL_DONE   = 10;

  // Statistic indices
  localparam int unsigned TEC_ST_RESEND      = 0;
  localparam int unsigned TEC_ST_RESEND_DROP = 1;
  localparam int unsigned TEC_ST_BAD_TRIG    = 2;
  localparam int unsigned TEC_ST_IMG_LOST    = 3;
  localparam int unsigned TEC_ST_PAUSE_RX    = 4;

  typedef enum logic [1:0] {
    TEC_NTF_OFF  = 2'h0,
    TEC_NTF_ON   = 2'h1,
    TEC_NTF_ONCE = 2'h2
  } tec_notify_t;

  typedef enum logic [1:0] {
    TEC_SYNC_OFF  = 2'h0,
    TEC_SYNC_AUTO = 2'h1
  } tec_sync_mode_t;

  typedef enum logic [1:0] {
    TEC_TX_IDLE = 2'b01,
    TEC_TX_BUSY = 2'b10
  } tec_tx_state_t;

  // Reset values
  localparam logic           TEC_SRC_RST  = 1'b0;
  localparam tec_sync_mode_t TEC_MODE_RST = TEC_SYNC_OFF;
  localparam tec_notify_t    TEC_NTF_RST  = TEC_NTF_OFF;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [TEC_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } tec_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tec_apb_rsp_t;

  typedef struct packed {
    logic [TEC_EVT_ID_W-1:0] id;
    logic [63:0]             stamp;
  } tec_evt_t;

endpackage

// >>> hw/tec_core.sv
// Timestamp counter, capture, statistics and event notification with an APB slave.
// Assumes event, statistic and precision-time inputs come from logic on mclk.
//
// Behaviour
// - Keep a readable 64-bit nanosecond timestamp counter.
// - Software selects the counter source: local clock or network time.
// - Local source advances the counter from the block's own clock.
// - Enabling precision time forces the network source, which then governs the counter.
// - Capture command copies the current counter into the captured value.
// - Captured value is 64 bits, equal to the counter at the command.
// - Clear command sets the counter to zero.
// - After a clear as slave, the counter resynchronises to the master.
// - Statistic readout returns the count chosen by the statistic selector.
// - Notify target selector picks which event's setting is read and written.
// - Setting Off: the event is never sent.
// - Setting On: every occurrence of the event is sent.
// - Setting Once: next occurrence is sent, then the setting turns Off.
// - Capture begin and capture finish commands each send an enabled event.
// - A link rate change sends an enabled event.
// - Error, warning and info messages each send their own enabled event.
// - Each of the three alarms sends its own enabled event.
// - Noise calibration start and completion each send an enabled event.
// - Sync mode Off disables the protocol; the network source bit still lets ptp_time_value load the counter.
// - Sync mode automatic enables the protocol; role comes from master selection.
// - Dropped resend requests still increment their statistic.
`timescale 1ns/1ps
module tec_core
  import tec_pkg::*;
(
  input  wire logic                               mclk,
  input  wire logic                               arst_n,
  input  wire tec_pkg::tec_apb_req_t              apb_req,
  output tec_pkg::tec_apb_rsp_t                   apb_rsp,
  input  wire logic                               capture_begin_event,
  input  wire logic                               capture_finish_event,
  input  wire logic                               link_rate_change_event,
  input  wire logic                               error_message_event,
  input  wire logic                               warning_message_event,
  input  wire logic                               info_message_event,
  input  wire logic                               first_alarm_event,
  input  wire logic                               second_alarm_event,
  input  wire logic                               third_alarm_event,
  input  wire logic                               noise_cal_begin_event,
  input  wire logic                               noise_cal_done_event,
  input  wire logic [tec_pkg::TEC_NUM_STATS-1:0]  stat_inc,
  input  wire logic                               ptp_time_load,
  input  wire logic [63:0]                        ptp_time_value,
  input  wire logic                               ptp_is_slave,
  output logic                                    ptp_enable,
  output logic                                    ptp_resync_req,
  output logic                                    evt_valid,
  input  wire logic                               evt_ready,
  output tec_pkg::tec_evt_t                       evt_out
);
  import tec_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic                       apb_setup;
  logic                       apb_access;
  logic                       wr_ok;
  logic [31:0]                rd_next;
  logic                       err_next;
  logic [31:0]                rd_reg;
  logic                       err_reg;
  logic                       time_base_select_reg;
  tec_sync_mode_t             sync_mode_reg;
  logic [63:0]                time_reg;
  logic [63:0]                captured_time_reg;
  logic [31:0]                time_hi_shadow_reg;
  logic [2:0]                 stat_select_reg;
  logic [3:0]                 notify_target_select_reg;
  logic [31:0]                stat_reg [TEC_NUM_STATS];
  tec_notify_t                notify_reg [TEC_NUM_EVENTS];
  logic [TEC_NUM_EVENTS-1:0]  occur;
  logic [TEC_NUM_EVENTS-1:0]  gated;
  logic [TEC_NUM_EVENTS-1:0]  pend_reg;
  logic [TEC_NUM_EVENTS-1:0]  take;
  logic                       net_src;
  logic                       cmd_capture;
  logic                       cmd_clear;
  logic                       wr_sel_set;
  tec_tx_state_t              tx_state_reg;
  logic                       tx_load;
  logic [TEC_EVT_ID_W-1:0]    next_id;
  logic                       any_pend;

  assign apb_setup  = apb_req.psel & ~apb_req.penable;
  assign apb_access = apb_req.psel & apb_req.penable;
  assign wr_ok      = apb_access & apb_req.pwrite & ~err_reg;

  // No wait state: data prepared in setup, answered in the first access cycle
  assign apb_rsp.pready  = apb_access;
  assign apb_rsp.pslverr = apb_access & err_reg;
  assign apb_rsp.prdata  = rd_reg;

  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    unique case (apb_req.paddr)
      TEC_OFS_CTRL: begin
        rd_next[TEC_CTRL_SRC_BIT] = time_base_select_reg;
        rd_next[TEC_CTRL_MODE_LSB +: 2] = sync_mode_reg;
      end
      TEC_OFS_CMD:      rd_next = 32'h0000_0000;
      TEC_OFS_TIME_LO:  rd_next = time_reg[31:0];
      TEC_OFS_TIME_HI:  rd_next = time_hi_shadow_reg;
      TEC_OFS_CAPT_LO:  rd_next = captured_time_reg[31:0];
      TEC_OFS_CAPT_HI:  rd_next = captured_time_reg[63:32];
      TEC_OFS_STAT_SEL: rd_next[2:0] = stat_select_reg;
      TEC_OFS_STAT_CNT: begin
        if (stat_select_reg < 3'(TEC_NUM_STATS)) begin
          rd_next = stat_reg[stat_select_reg];
        end
      end
      TEC_OFS_NTF_SEL:  rd_next[3:0] = notify_target_select_reg;
      TEC_OFS_NTF_SET: begin
        if (notify_target_select_reg < 4'(TEC_NUM_EVENTS)) begin
          rd_next[1:0] = notify_reg[notify_target_select_reg];
        end
      end
      TEC_OFS_STATUS: begin
        rd_next[TEC_STS_NET_BIT] = net_src;
        rd_next[TEC_STS_PTP_BIT] = ptp_enable;
        rd_next[TEC_STS_SLV_BIT] = ptp_is_slave;
      end
      default:          err_next = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg  <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (apb_setup) begin
      rd_reg  <= apb_req.pwrite ? 32'h0000_0000 : rd_next;
      err_reg <= err_next;
    end
  end

  // Low word read freezes the high word for a coherent 64-bit read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_hi_shadow_reg <= 32'h0000_0000;
    end else if (apb_setup && !apb_req.pwrite && apb_req.paddr == TEC_OFS_TIME_LO) begin
      time_hi_shadow_reg <= time_reg[63:32];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_base_select_reg <= TEC_SRC_RST;
      sync_mode_reg        <= TEC_MODE_RST;
    end else if (wr_ok && apb_req.paddr == TEC_OFS_CTRL) begin
      time_base_select_reg <= apb_req.pwdata[TEC_CTRL_SRC_BIT];
      if (apb_req.pwdata[TEC_CTRL_MODE_LSB +: 2] == TEC_SYNC_AUTO) begin
        sync_mode_reg <= TEC_SYNC_AUTO;
      end else if (apb_req.pwdata[TEC_CTRL_MODE_LSB +: 2] == TEC_SYNC_OFF) begin
        sync_mode_reg <= TEC_SYNC_OFF;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stat_select_reg          <= 3'h0;
      notify_target_select_reg <= 4'h0;
    end else if (wr_ok) begin
      if (apb_req.paddr == TEC_OFS_STAT_SEL) begin
        stat_select_reg <= apb_req.pwdata[2:0];
      end
      if (apb_req.paddr == TEC_OFS_NTF_SEL) begin
        notify_target_select_reg <= apb_req.pwdata[3:0];
      end
    end
  end

  assign ptp_enable  = (sync_mode_reg == TEC_SYNC_AUTO);
  assign net_src     = ptp_enable | time_base_select_reg;
  assign cmd_capture = wr_ok && apb_req.paddr == TEC_OFS_CMD && apb_req.pwdata[TEC_CMD_CAPT_BIT];
  assign cmd_clear   = wr_ok && apb_req.paddr == TEC_OFS_CMD && apb_req.pwdata[TEC_CMD_CLR_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Timestamp counter

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg <= 64'h0;
    end else if (cmd_clear) begin
      time_reg <= 64'h0;
    end else if (net_src && ptp_time_load) begin
      time_reg <= ptp_time_value;
    end else begin
      time_reg <= time_reg + TEC_TICK_NS;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      captured_time_reg <= 64'h0;
    end else if (cmd_capture) begin
      captured_time_reg <= time_reg;
    end
  end

  // Ask the protocol engine to realign after a clear as slave
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ptp_resync_req <= 1'b0;
    end else begin
      ptp_resync_req <= cmd_clear & ptp_enable & ptp_is_slave;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Statistics

  for (genvar s = 0; s < TEC_NUM_STATS; s++) begin : g_stat
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        stat_reg[s] <= 32'h0000_0000;
      end else if (stat_inc[s]) begin
        stat_reg[s] <= stat_reg[s] + 32'h0000_0001;
      end
    end
    a_stat_step: assert property (@(posedge mclk) disable iff (!arst_n)
      stat_inc[s] |=> stat_reg[s] == $past(stat_reg[s]) + 32'h0000_0001)
      else $error("statistic did not step");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event notification

  assign occur[TEC_EV_CAP_BEGIN]  = capture_begin_event;
  assign occur[TEC_EV_CAP_FINISH] = capture_finish_event;
  assign occur[TEC_EV_LINK_RATE]  = link_rate_change_event;
  assign occur[TEC_EV_ERROR]      = error_message_event;
  assign occur[TEC_EV_WARNING]    = warning_message_event;
  assign occur[TEC_EV_INFO]       = info_message_event;
  assign occur[TEC_EV_FIRST_ALARM_EVENT]     = first_alarm_event;
  assign occur[TEC_EV_SECOND_ALARM_EVENT]     = second_alarm_event;
  assign occur[TEC_EV_THIRD_ALARM_EVENT]     = third_alarm_event;
  assign occur[TEC_EV_CAL_BEGIN]  = noise_cal_begin_event;
  assign occur[TEC_EV_CAL_DONE]   = noise_cal_done_event;

  assign wr_sel_set = wr_ok && apb_req.paddr == TEC_OFS_NTF_SET;

  for (genvar e = 0; e < TEC_NUM_EVENTS; e++) begin : g_evt
    assign gated[e] = occur[e] && notify_reg[e] != TEC_NTF_OFF;

    // Software write wins over the automatic disable
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        notify_reg[e] <= TEC_NTF_RST;
      end else if (wr_sel_set && notify_target_select_reg == 4'(e)) begin
        unique case (apb_req.pwdata[1:0])
          TEC_NTF_ON:   notify_reg[e] <= TEC_NTF_ON;
          TEC_NTF_ONCE: notify_reg[e] <= TEC_NTF_ONCE;
          default:      notify_reg[e] <= TEC_NTF_OFF;
        endcase
      end else if (occur[e] && notify_reg[e] == TEC_NTF_ONCE) begin
        notify_reg[e] <= TEC_NTF_OFF;
      end
    end

    // New occurrence wins over the clear by the sender
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        pend_reg[e] <= 1'b0;
      end else begin
        pend_reg[e] <= (pend_reg[e] & ~take[e]) | gated[e];
      end
    end

    a_off_silent: assert property (@(posedge mclk) disable iff (!arst_n)
      !pend_reg[e] && notify_reg[e] == TEC_NTF_OFF |=> !pend_reg[e])
      else $error("disabled event became pending");
    a_on_pending: assert property (@(posedge mclk) disable iff (!arst_n)
      occur[e] && notify_reg[e] == TEC_NTF_ON |=> pend_reg[e] && notify_reg[e] == TEC_NTF_ON
        || $past(wr_sel_set))
      else $error("enabled event not queued");
    a_once_drop: assert property (@(posedge mclk) disable iff (!arst_n)
      occur[e] && notify_reg[e] == TEC_NTF_ONCE && !wr_sel_set
        |=> pend_reg[e] && notify_reg[e] == TEC_NTF_OFF)
      else $error("once setting not consumed");
  end

  always_comb begin
    next_id = '0;
    for (int i = TEC_NUM_EVENTS - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        next_id = TEC_EVT_ID_W'(i);
      end
    end
  end

  assign any_pend = |pend_reg;
  assign tx_load  = any_pend && (tx_state_reg == TEC_TX_IDLE || evt_ready);

  for (genvar t = 0; t < TEC_NUM_EVENTS; t++) begin : g_take
    assign take[t] = tx_load && next_id == TEC_EVT_ID_W'(t);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg <= TEC_TX_IDLE;
    end else begin
      unique case (tx_state_reg)
        TEC_TX_IDLE: if (tx_load) tx_state_reg <= TEC_TX_BUSY;
        TEC_TX_BUSY: if (evt_ready && !tx_load) tx_state_reg <= TEC_TX_IDLE;
        default:     tx_state_reg <= TEC_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_out <= '0;
    end else if (tx_load) begin
      evt_out.id    <= next_id;
      evt_out.stamp <= time_reg;
    end
  end

  assign evt_valid = (tx_state_reg == TEC_TX_BUSY);

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_clear_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd_clear |=> time_reg == 64'h0)
    else $error("clear did not zero counter");
  a_capture_val: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd_capture |=> captured_time_reg == $past(time_reg))
    else $error("capture value wrong");
  a_local_step: assert property (@(posedge mclk) disable iff (!arst_n)
    !net_src && !cmd_clear |=> time_reg == $past(time_reg) + TEC_TICK_NS)
    else $error("local step wrong");
  a_net_load: assert property (@(posedge mclk) disable iff (!arst_n)
    net_src && ptp_time_load && !cmd_clear |=> time_reg == $past(ptp_time_value))
    else $error("network time not taken");
  a_sync_off: assert property (@(posedge mclk) disable iff (!arst_n)
    sync_mode_reg == TEC_SYNC_OFF |-> !ptp_enable && net_src == time_base_select_reg)
    else $error("protocol active while off");
  a_auto_net: assert property (@(posedge mclk) disable iff (!arst_n)
    sync_mode_reg == TEC_SYNC_AUTO |-> ptp_enable && net_src)
    else $error("automatic mode not on network source");
  a_resync_req: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd_clear && ptp_enable && ptp_is_slave |=> ptp_resync_req ##1 !ptp_resync_req
      || cmd_clear)
    else $error("resync request missing");
  a_evt_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    evt_valid && !evt_ready |=> evt_valid && $stable(evt_out))
    else $error("event dropped before accept");
  a_cnt_read: assert property (@(posedge mclk) disable iff (!arst_n)
    apb_setup && !apb_req.pwrite && apb_req.paddr == TEC_OFS_STAT_CNT
      && stat_select_reg == 3'h1 |=> rd_reg == $past(stat_reg[1]))
    else $error("statistic readout wrong");

  c_capture:   cover property (@(posedge mclk) disable iff (!arst_n) cmd_capture);
  c_net_clear: cover property (@(posedge mclk) disable iff (!arst_n)
    cmd_clear && ptp_enable && ptp_is_slave);
  c_evt_sent:  cover property (@(posedge mclk) disable iff (!arst_n) evt_valid && evt_ready);
  c_stall:     cover property (@(posedge mclk) disable iff (!arst_n)
    evt_valid && !evt_ready ##1 evt_valid && evt_ready);

endmodule

// >>> verif/tec_evt_sink.sv
// Host-side receiver of control-channel events, with optional random stalls.
// Assumes evt_valid and evt_out hold until accepted on mclk.
`timescale 1ns/1ps
module tec_evt_sink
  import tec_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              slow,
  input  wire logic              evt_valid,
  input  wire tec_pkg::tec_evt_t evt_out,
  output logic                   evt_ready
);
  int          rx_q[$];
  logic [63:0] st_q[$];

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_ready <= 1'b0;
    end else begin
      if (evt_valid && evt_ready) begin
        rx_q.push_back(int'(evt_out.id));
        st_q.push_back(evt_out.stamp);
      end
      evt_ready <= slow ? 1'($urandom % 2) : 1'b1;
    end
  end
endmodule

// >>> verif/timestamp_event_control_test.sv
// Self-checking bench for the timestamp and event block.
// Assumes an APB master here and the event receiver model beside the design.
`timescale 1ns/1ps
module timestamp_event_control_test;
  import tec_pkg::*;
  logic         mclk, arst_n, slow, ptp_load, slave, evt_valid, evt_ready, ptp_en, rs, err;
  logic [10:0]  ev;
  logic [4:0]   st;
  logic [63:0]  ptp_val, a, b, ls;
  logic [31:0]  rd;
  tec_apb_req_t req;
  tec_apb_rsp_t rsp;
  tec_evt_t     evt;
  int           errors, total_checks, cyc, t0, tc, ta, tl, n_rs, r, i, tp, lp;
  int           exp_q[$];

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  tec_core uut (.mclk(mclk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .capture_begin_event(ev[0]), .capture_finish_event(ev[1]),
    .link_rate_change_event(ev[2]), .error_message_event(ev[3]),
    .warning_message_event(ev[4]), .info_message_event(ev[5]),
    .first_alarm_event(ev[6]), .second_alarm_event(ev[7]), .third_alarm_event(ev[8]),
    .noise_cal_begin_event(ev[9]), .noise_cal_done_event(ev[10]), .stat_inc(st),
    .ptp_time_load(ptp_load), .ptp_time_value(ptp_val), .ptp_is_slave(slave),
    .ptp_enable(ptp_en), .ptp_resync_req(rs), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_out(evt));

  tec_evt_sink sink (.mclk(mclk), .arst_n(arst_n), .slow(slow), .evt_valid(evt_valid),
    .evt_out(evt), .evt_ready(evt_ready));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rs === 1'b1) n_rs <= n_rs + 1;
    if (cyc > 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    t0 = cyc;
    req <= '0;
    @(posedge mclk);
  endtask

  // Capture, then read both halves
  task automatic cap(output logic [63:0] v);
    apb(1'b1, TEC_OFS_CMD, 32'h1);
    tc = t0;
    apb(1'b0, TEC_OFS_CAPT_LO, 32'h0);
    v[31:0] = rd;
    apb(1'b0, TEC_OFS_CAPT_HI, 32'h0);
    v[63:32] = rd;
  endtask

  task automatic pulse_ev(input int k);
    ev[k] <= 1'b1;
    tp = cyc;
    @(posedge mclk);
    ev <= '0;
    repeat (40) @(posedge mclk);
    chk("event count", sink.rx_q.size(), exp_q.size());
    if (sink.rx_q.size() == exp_q.size()) begin
      foreach (exp_q[k2]) chk("event id", sink.rx_q[k2], exp_q[k2]);
    end
    // Stamp steps with the local counter between sends
    if (sink.st_q.size() == 1) begin
      if (lp > 0) chk("event stamp", sink.st_q[0] - ls, 64'(4 * (tp - lp)));
      ls = sink.st_q[0];
      lp = tp;
    end
    sink.rx_q.delete();
    sink.st_q.delete();
    exp_q.delete();
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5177));
    {arst_n, slow, ptp_load, slave, ev, st, ptp_val, req} = '0;
    {errors, total_checks, cyc, n_rs} = '0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, TEC_OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 64'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", err, 64'h1);
    $display("test reset done");
    cap(a);
    ta = tc;
    repeat ($urandom_range(1, 20)) @(posedge mclk);
    cap(b);
    chk("local step", b - a, 64'(4 * (tc - ta)));
    apb(1'b1, TEC_OFS_CMD, 32'h2);
    ta = t0;
    cap(a);
    chk("clear", a, 64'(4 * (tc - ta - 1)));
    apb(1'b1, TEC_OFS_CTRL, 32'h1);
    ptp_val <= {$urandom, $urandom};
    ptp_load <= 1'b1;
    tl = cyc;
    @(posedge mclk);
    ptp_load <= 1'b0;
    cap(a);
    chk("net load", a, ptp_val + 64'(4 * (tc - tl - 2)));
    apb(1'b0, TEC_OFS_TIME_LO, 32'h0);
    b[31:0] = rd;
    tl = t0;
    apb(1'b0, TEC_OFS_TIME_HI, 32'h0);
    b[63:32] = rd;
    chk("time read", b, a + 64'(4 * (tl - 1 - tc)));
    apb(1'b1, TEC_OFS_CTRL, 32'h2);
    chk("sync auto", ptp_en, 64'h1);
    apb(1'b0, TEC_OFS_STATUS, 32'h0);
    chk("status", rd[1:0], 64'h3);
    apb(1'b1, TEC_OFS_CTRL, 32'h6);
    chk("mode kept", ptp_en, 64'h1);
    slave <= 1'b1;
    apb(1'b1, TEC_OFS_CMD, 32'h2);
    repeat (2) @(posedge mclk);
    chk("resync", n_rs, 64'h1);
    apb(1'b1, TEC_OFS_CTRL, 32'h0);
    chk("sync off", ptp_en, 64'h0);
    slave <= 1'b0;
    $display("test timestamp done");
    slow <= 1'b1;
    for (i = 0; i < 11; i++) begin
      apb(1'b1, TEC_OFS_NTF_SEL, 32'(i));
      apb(1'b1, TEC_OFS_NTF_SET, 32'(TEC_NTF_ON));
      exp_q.push_back(i);
      pulse_ev(i);
    end
    r = $urandom_range(0, 10);
    apb(1'b1, TEC_OFS_NTF_SEL, 32'(r));
    apb(1'b1, TEC_OFS_NTF_SET, 32'(TEC_NTF_ONCE));
    exp_q.push_back(r);
    pulse_ev(r);
    pulse_ev(r);
    apb(1'b0, TEC_OFS_NTF_SET, 32'h0);
    chk("once off", rd, 64'h0);
    apb(1'b1, TEC_OFS_NTF_SET, 32'(TEC_NTF_ON));
    apb(1'b1, TEC_OFS_NTF_SET, 32'h3);
    apb(1'b0, TEC_OFS_NTF_SET, 32'h0);
    chk("code three off", rd, 64'h0);
    $display("test events done");
    for (i = 0; i < 5; i++) begin
      r = $urandom_range(1, 6);
      st[i] <= 1'b1;
      repeat (r) @(posedge mclk);
      st <= '0;
      apb(1'b1, TEC_OFS_STAT_SEL, 32'(i));
      apb(1'b0, TEC_OFS_STAT_CNT, 32'h0);
      chk("stat count", rd, 64'(r));
    end
    $display("test statistics done");
    complete_run();
  end
endmodule
